// *** verilog/scsr_pkg.sv ***
package scsr_pkg;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_RSVD_CFG_A    = 8'h06;
    localparam logic [7:0] ADDR_RSVD_CFG_B    = 8'h07;
    localparam logic [7:0] ADDR_CABLE_FAULT   = 8'h08;
    localparam logic [7:0] ADDR_RSVD_STAT_A   = 8'h09;
    localparam logic [7:0] ADDR_RSVD_STAT_B   = 8'h0A;
    localparam logic [7:0] ADDR_RSVD_STAT_C   = 8'h0B;
    localparam logic [7:0] ADDR_RSVD_CFG_C    = 8'h0C;
    localparam logic [7:0] ADDR_PIN_SYNC_POL  = 8'h0D;
    localparam logic [7:0] ADDR_DE_POL        = 8'h0E;
    localparam logic [7:0] ADDR_XLATE_A_SRC   = 8'h0F;
    localparam logic [7:0] ADDR_XLATE_A_DST   = 8'h10;
    localparam logic [7:0] ADDR_XLATE_B_SRC   = 8'h11;
    localparam logic [7:0] ADDR_XLATE_B_DST   = 8'h12;

    // ---------------------------------------------------------------
    // fixed and reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_RSVD_CFG_A     = 8'h40;
    localparam logic [7:0] RST_RSVD_CFG_B     = 8'h22;
    localparam logic [7:0] RST_RSVD_CFG_C     = 8'h20;
    localparam logic [7:0] RST_RSVD_STATUS    = 8'h00;
    localparam logic [3:0] RSVD_FAULT_HIGH    = 4'h0;
    localparam logic [4:0] RSVD_PIN_SYNC_LOW  = 5'h0F;
    localparam logic [6:0] RSVD_DE_POL_LOW    = 7'h02;
    localparam logic [6:0] RST_XLATE_ADDR     = 7'h00;
    localparam logic       RST_CTRL_BIT       = 1'b0;
    localparam logic [7:0] UNMAPPED_READ      = 8'h00;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int OUT_LEVEL_BIT  = 7;
    localparam int VSYNC_INV_BIT  = 6;
    localparam int HSYNC_INV_BIT  = 5;
    localparam int DE_INV_BIT     = 7;
    localparam int XLATE_ADDR_LSB = 1;
    localparam int NEG_FAULT_LSB  = 2;
    localparam int POS_FAULT_LSB  = 0;

    // ---------------------------------------------------------------
    // cable wire state encoding
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        WIRE_SHORT_SUPPLY = 2'b00,
        WIRE_SHORT_GROUND = 2'b01,
        WIRE_NORMAL       = 2'b10,
        WIRE_OPEN         = 2'b11
    } scsr_wire_state_t;

    // ---------------------------------------------------------------
    // counts and boost off level
    // ---------------------------------------------------------------
    localparam int SYNC_STAGES      = 3;
    localparam int READ_LATENCY_CYC = 1;
    localparam logic [3:0] BOOST_OFF = 4'h0;

endpackage : scsr_pkg

// *** verilog/scsr_sync.sv ***
`timescale 1ns/100ps

// ---------------------------------------------------------------
// three-stage pin synchroniser, change accepted when stages 2 and 3 agree
// ---------------------------------------------------------------
module scsr_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             sys_clk,   // system clock
    input  wire logic             rst_n,     // sync reset, active low
    input  wire logic             ce,        // clock enable
    input  wire logic [WIDTH-1:0] pin_in,    // asynchronous pin level
    output logic      [WIDTH-1:0] clean_out  // filtered synchronous level
);

    if (WIDTH < 1) begin : g_bad_width
        $error("scsr_sync: WIDTH must be at least 1");
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic stage1;
        logic stage2;
        logic stage3;

        // stage1 is read by stage2 alone, to keep metastability contained
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                stage1 <= RESET_VAL[i];
                stage2 <= RESET_VAL[i];
                stage3 <= RESET_VAL[i];
            end else if (ce) begin
                stage1 <= pin_in[i];
                stage2 <= stage1;
                stage3 <= stage2;
            end
        end

        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                clean_out[i] <= RESET_VAL[i];
            end else if (ce && (stage2 == stage3)) begin
                clean_out[i] <= stage3;
            end
        end
    end

endmodule : scsr_sync

// *** verilog/scsr_xlate.sv ***
`timescale 1ns/100ps

// ---------------------------------------------------------------
// two-entry bus address translator, one cycle latency
// ---------------------------------------------------------------
module scsr_xlate #(
    parameter int AW = 7
) (
    input  wire logic          sys_clk,    // system clock
    input  wire logic          rst_n,      // sync reset, active low
    input  wire logic          ce,         // clock enable
    input  wire logic [AW-1:0] src_a,      // translator a source
    input  wire logic [AW-1:0] dst_a,      // translator a destination
    input  wire logic [AW-1:0] src_b,      // translator b source
    input  wire logic [AW-1:0] dst_b,      // translator b destination
    input  wire logic [AW-1:0] in_addr,    // target address of transaction
    input  wire logic          in_valid,   // transaction address strobe
    output logic      [AW-1:0] out_addr,   // forwarded address
    output logic               out_valid,  // forwarded address strobe
    output logic               out_hit     // address was substituted
);

    if (AW != 7) begin : g_bad_aw
        $error("scsr_xlate: only 7-bit bus addresses are served");
    end

    function automatic logic addr_match(input logic [AW-1:0] a, input logic [AW-1:0] b);
        addr_match = (a == b);
    endfunction : addr_match

    // entry a wins when both sources hold the same address
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            out_addr  <= '0;
            out_valid <= 1'b0;
            out_hit   <= 1'b0;
        end else if (ce) begin
            out_valid <= in_valid;
            if (in_valid && addr_match(in_addr, src_a)) begin
                out_addr <= dst_a;
                out_hit  <= 1'b1;
            end else if (in_valid && addr_match(in_addr, src_b)) begin
                out_addr <= dst_b;
                out_hit  <= 1'b1;
            end else begin
                out_addr <= in_addr;
                out_hit  <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    xlate_a_hit_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && in_valid && in_addr == src_a) |=> (out_valid && out_hit && out_addr == $past(dst_a)))
        else $error("translator a did not substitute");

    xlate_b_hit_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && in_valid && in_addr != src_a && in_addr == src_b)
        |=> (out_hit && out_addr == $past(dst_b)))
        else $error("translator b did not substitute");

    xlate_miss_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && in_valid && in_addr != src_a && in_addr != src_b)
        |=> (!out_hit && out_addr == $past(in_addr)))
        else $error("unmatched address was altered");

    xlate_hit_c : cover property (@(posedge sys_clk) disable iff (!rst_n)
        ce && in_valid && in_addr == src_b ##1 out_hit);

endmodule : scsr_xlate

// *** verilog/scsr_top.sv ***
`timescale 1ns/100ps

// How it works
// - negative wire state read-only at bits 3:2, encoded four ways, normal 10.
// - positive wire state read-only at bits 1:0, same encoding, normal 10.
// - output pin follows the output level bit, cleared at reset.
// - vertical sync inverted when its invert bit set, passed through otherwise.
// - horizontal sync inverted when its invert bit set, passed through otherwise.
// - data enable inverted when upper bit set, reset to no inversion.
// - translator a source and destination in bits 7:1, reset zero, bit 0 zero.
// - translator b source and destination in bits 7:1 of next two, reset zero.
module scsr_top (
    input  wire logic       sys_clk,            // system clock, 100 MHz
    input  wire logic       rst_n,              // sync reset, active low
    input  wire logic       ce,                 // clock enable, freezes all state
    input  wire logic [7:0] reg_addr,           // register offset
    input  wire logic [7:0] reg_wdata,          // write data
    input  wire logic       reg_wr,             // write strobe
    input  wire logic       reg_rd,             // read strobe
    output logic      [7:0] reg_rdata,          // read data
    output logic            reg_rvalid,         // read data valid pulse
    input  wire logic [1:0] neg_wire_sense,     // negative wire detector pins
    input  wire logic [1:0] pos_wire_sense,     // positive wire detector pins
    input  wire logic       vsync_in,           // vertical sync pin
    input  wire logic       hsync_in,           // horizontal sync pin
    input  wire logic       de_in,              // data enable pin
    output logic            vsync_out,          // vertical sync after polarity
    output logic            hsync_out,          // horizontal sync after polarity
    output logic            de_out,             // data enable after polarity
    output logic            general_output_pin, // general purpose output pin
    input  wire logic [3:0] boost_code,         // pre-emphasis code field
    output logic      [3:0] output_boost_level, // static boost level to driver
    input  wire logic [6:0] xl_in_addr,         // bus target address
    input  wire logic       xl_in_valid,        // bus target address strobe
    output logic      [6:0] xl_out_addr,        // forwarded bus address
    output logic            xl_out_valid,       // forwarded address strobe
    output logic            xl_out_hit          // forwarded address was translated
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic       output_pin_level;
    logic       vert_sync_invert;
    logic       horiz_sync_invert;
    logic       data_enable_invert;
    logic [6:0] xlate_a_source;
    logic [6:0] xlate_a_destination;
    logic [6:0] xlate_b_source;
    logic [6:0] xlate_b_destination;
    logic [1:0] neg_wire_fault;
    logic [1:0] pos_wire_fault;
    logic       vs_clean;
    logic       hs_clean;
    logic       de_clean;
    logic [7:0] next_rdata;
    logic       wr_en;

    assign wr_en = ce && reg_wr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] offset);
        hit = (a == offset);
    endfunction : hit

    function automatic logic [3:0] boost_decode(input logic [3:0] code);
        // lower codes select de-emphasis or are unusable; the driver sees no boost
        if (code[3]) begin
            boost_decode = {1'b0, code[2:0]} + 4'h1;
        end else begin
            boost_decode = scsr_pkg::BOOST_OFF;
        end
    endfunction : boost_decode

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    scsr_sync #(
        .WIDTH     (4),
        .RESET_VAL ({scsr_pkg::WIRE_NORMAL, scsr_pkg::WIRE_NORMAL})
    ) u_fault_sync (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .pin_in    ({neg_wire_sense, pos_wire_sense}),
        .clean_out ({neg_wire_fault, pos_wire_fault})
    );

    scsr_sync #(
        .WIDTH     (3),
        .RESET_VAL (3'h0)
    ) u_video_sync (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .pin_in    ({vsync_in, hsync_in, de_in}),
        .clean_out ({vs_clean, hs_clean, de_clean})
    );

    // ---------------------------------------------------------------
    // control register writes
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            output_pin_level  <= scsr_pkg::RST_CTRL_BIT;
            vert_sync_invert  <= scsr_pkg::RST_CTRL_BIT;
            horiz_sync_invert <= scsr_pkg::RST_CTRL_BIT;
        end else if (wr_en && hit(reg_addr, scsr_pkg::ADDR_PIN_SYNC_POL)) begin
            output_pin_level  <= reg_wdata[scsr_pkg::OUT_LEVEL_BIT];
            vert_sync_invert  <= reg_wdata[scsr_pkg::VSYNC_INV_BIT];
            horiz_sync_invert <= reg_wdata[scsr_pkg::HSYNC_INV_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            data_enable_invert <= scsr_pkg::RST_CTRL_BIT;
        end else if (wr_en && hit(reg_addr, scsr_pkg::ADDR_DE_POL)) begin
            data_enable_invert <= reg_wdata[scsr_pkg::DE_INV_BIT];
        end
    end

    // ---------------------------------------------------------------
    // translator address registers
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            xlate_a_source      <= scsr_pkg::RST_XLATE_ADDR;
            xlate_a_destination <= scsr_pkg::RST_XLATE_ADDR;
        end else if (wr_en) begin
            if (hit(reg_addr, scsr_pkg::ADDR_XLATE_A_SRC)) begin
                xlate_a_source <= reg_wdata[7:scsr_pkg::XLATE_ADDR_LSB];
            end else if (hit(reg_addr, scsr_pkg::ADDR_XLATE_A_DST)) begin
                xlate_a_destination <= reg_wdata[7:scsr_pkg::XLATE_ADDR_LSB];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            xlate_b_source      <= scsr_pkg::RST_XLATE_ADDR;
            xlate_b_destination <= scsr_pkg::RST_XLATE_ADDR;
        end else if (wr_en) begin
            if (hit(reg_addr, scsr_pkg::ADDR_XLATE_B_SRC)) begin
                xlate_b_source <= reg_wdata[7:scsr_pkg::XLATE_ADDR_LSB];
            end else if (hit(reg_addr, scsr_pkg::ADDR_XLATE_B_DST)) begin
                xlate_b_destination <= reg_wdata[7:scsr_pkg::XLATE_ADDR_LSB];
            end
        end
    end

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    // reserved and read-only offsets ignore writes; anything else reads zero
    always_comb begin
        if (hit(reg_addr, scsr_pkg::ADDR_RSVD_CFG_A)) begin
            next_rdata = scsr_pkg::RST_RSVD_CFG_A;
        end else if (hit(reg_addr, scsr_pkg::ADDR_RSVD_CFG_B)) begin
            next_rdata = scsr_pkg::RST_RSVD_CFG_B;
        end else if (hit(reg_addr, scsr_pkg::ADDR_CABLE_FAULT)) begin
            next_rdata = {scsr_pkg::RSVD_FAULT_HIGH, neg_wire_fault, pos_wire_fault};
        end else if (hit(reg_addr, scsr_pkg::ADDR_RSVD_STAT_A) ||
                     hit(reg_addr, scsr_pkg::ADDR_RSVD_STAT_B) ||
                     hit(reg_addr, scsr_pkg::ADDR_RSVD_STAT_C)) begin
            next_rdata = scsr_pkg::RST_RSVD_STATUS;
        end else if (hit(reg_addr, scsr_pkg::ADDR_RSVD_CFG_C)) begin
            next_rdata = scsr_pkg::RST_RSVD_CFG_C;
        end else if (hit(reg_addr, scsr_pkg::ADDR_PIN_SYNC_POL)) begin
            next_rdata = {output_pin_level, vert_sync_invert, horiz_sync_invert,
                          scsr_pkg::RSVD_PIN_SYNC_LOW};
        end else if (hit(reg_addr, scsr_pkg::ADDR_DE_POL)) begin
            next_rdata = {data_enable_invert, scsr_pkg::RSVD_DE_POL_LOW};
        end else if (hit(reg_addr, scsr_pkg::ADDR_XLATE_A_SRC)) begin
            next_rdata = {xlate_a_source, 1'b0};
        end else if (hit(reg_addr, scsr_pkg::ADDR_XLATE_A_DST)) begin
            next_rdata = {xlate_a_destination, 1'b0};
        end else if (hit(reg_addr, scsr_pkg::ADDR_XLATE_B_SRC)) begin
            next_rdata = {xlate_b_source, 1'b0};
        end else if (hit(reg_addr, scsr_pkg::ADDR_XLATE_B_DST)) begin
            next_rdata = {xlate_b_destination, 1'b0};
        end else begin
            next_rdata = scsr_pkg::UNMAPPED_READ;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata  <= scsr_pkg::UNMAPPED_READ;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // ---------------------------------------------------------------
    // outputs driven from state
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            general_output_pin <= scsr_pkg::RST_CTRL_BIT;
        end else if (ce) begin
            general_output_pin <= output_pin_level;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vsync_out <= 1'b0;
            hsync_out <= 1'b0;
            de_out    <= 1'b0;
        end else if (ce) begin
            vsync_out <= vs_clean ^ vert_sync_invert;
            hsync_out <= hs_clean ^ horiz_sync_invert;
            de_out    <= de_clean ^ data_enable_invert;
        end
    end

    // static setting; the driver samples it whenever it likes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            output_boost_level <= scsr_pkg::BOOST_OFF;
        end else if (ce) begin
            output_boost_level <= boost_decode(boost_code);
        end
    end

    // ---------------------------------------------------------------
    // address translator
    // ---------------------------------------------------------------
    scsr_xlate #(
        .AW        (7)
    ) u_xlate (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .src_a     (xlate_a_source),
        .dst_a     (xlate_a_destination),
        .src_b     (xlate_b_source),
        .dst_b     (xlate_b_destination),
        .in_addr   (xl_in_addr),
        .in_valid  (xl_in_valid),
        .out_addr  (xl_out_addr),
        .out_valid (xl_out_valid),
        .out_hit   (xl_out_hit)
    );

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    fault_read_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && reg_rd && reg_addr == scsr_pkg::ADDR_CABLE_FAULT)
        |=> (reg_rvalid && reg_rdata == {4'h0, $past(neg_wire_fault), $past(pos_wire_fault)}))
        else $error("cable fault read mismatch");

    pos_wire_normal_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && pos_wire_sense == 2'h2) [*4] |=> (pos_wire_fault == 2'h2))
        else $error("steady normal positive wire not reported");

    pin_level_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && reg_wr && reg_addr == scsr_pkg::ADDR_PIN_SYNC_POL) ##1 ce
        |=> (general_output_pin == $past(reg_wdata[7], 2)))
        else $error("output pin does not follow level bit");

    vsync_pol_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce |=> (vsync_out == ($past(vs_clean) ^ $past(vert_sync_invert))))
        else $error("vertical sync polarity wrong");

    hsync_pol_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce |=> (hsync_out == ($past(hs_clean) ^ $past(horiz_sync_invert))))
        else $error("horizontal sync polarity wrong");

    de_pol_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && reg_wr && reg_addr == scsr_pkg::ADDR_DE_POL) ##1 (ce && de_clean == 1'b0)
        |=> (de_out == $past(reg_wdata[7], 2)))
        else $error("data enable inversion not applied");

    xlate_a_reg_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && reg_wr && reg_addr == scsr_pkg::ADDR_XLATE_A_SRC) ##1 (ce && !reg_wr)
        ##1 (ce && reg_rd && !reg_wr && reg_addr == scsr_pkg::ADDR_XLATE_A_SRC)
        |=> (reg_rdata == {$past(reg_wdata[7:1], 3), 1'b0}))
        else $error("translator a source readback wrong");

    xlate_b_reg_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && reg_wr && reg_addr == scsr_pkg::ADDR_XLATE_B_DST)
        |=> (xlate_b_destination == $past(reg_wdata[7:1])))
        else $error("translator b destination not stored");

    boost_level_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && boost_code == 4'hF) |=> (output_boost_level == 4'h8))
        else $error("top boost code not decoded to level 8");

    rsvd_read_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && reg_rd && reg_addr == scsr_pkg::ADDR_RSVD_CFG_A) |=> (reg_rdata == 8'h40))
        else $error("reserved register reads wrong value");

    pin_high_c : cover property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(general_output_pin));

    fault_open_c : cover property (@(posedge sys_clk) disable iff (!rst_n)
        neg_wire_fault == 2'h3);

    de_invert_c : cover property (@(posedge sys_clk) disable iff (!rst_n)
        data_enable_invert && ce ##1 de_out);

endmodule : scsr_top

// *** verif/scsr_mcu.sv ***
`timescale 1ns/100ps
// ------------------------------------------
// controller side of the register port
// ------------------------------------------
module scsr_mcu (
    input  wire logic       sys_clk,    // system clock
    output logic      [7:0] reg_addr,   // offset
    output logic      [7:0] reg_wdata,  // write data
    output logic            reg_wr,     // write strobe
    output logic            reg_rd,     // read strobe
    input  wire logic [7:0] reg_rdata,  // read data
    input  wire logic       reg_rvalid  // read valid
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge sys_clk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(posedge sys_clk);
        #1 reg_wr = 0;
        reg_rd = 0;
        // released lines show junk, not the last value
        reg_wdata = ~d;
        reg_addr = ~a;
        q = (w || reg_rvalid) ? reg_rdata : 8'hXX;
    endtask : acc
endmodule : scsr_mcu

// *** verif/scsr_top_tb.sv ***
`timescale 1ns/100ps
module scsr_top_tb;
    logic       sys_clk = 0;
    logic       rst_n = 0;
    logic       ce = 1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, q, ra, sd = 8'h36;
    logic       reg_wr, reg_rd, reg_rvalid, xv = 0, xov, xh, vo, ho, deo, op;
    logic [1:0] neg = 2'b10, pos = 2'b10;
    logic [2:0] sy = 0;
    logic [3:0] bc = 0, bl;
    logic [6:0] xa = 0, xo;
    logic [7:0] sh [256];
    int         mismatches = 0, checks_done = 0;
    scsr_mcu scsr_mcu_i (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .reg_rvalid);
    scsr_top scsr_top_i (.sys_clk, .rst_n, .ce(ce), .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .neg_wire_sense(neg),
        .pos_wire_sense(pos), .vsync_in(sy[2]), .hsync_in(sy[1]), .de_in(sy[0]),
        .vsync_out(vo), .hsync_out(ho), .de_out(deo), .general_output_pin(op),
        .boost_code(bc), .output_boost_level(bl), .xl_in_addr(xa),
        .xl_in_valid(xv), .xl_out_addr(xo), .xl_out_valid(xov), .xl_out_hit(xh));
    function automatic logic [7:0] lf(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lf
    // reserved bits keep their fixed value whatever is written
    function automatic logic [7:0] mk(input logic [7:0] a, d);
        case (a)
            8'h0D: return (d & 8'hE0) | 8'h0F;
            8'h0E: return (d & 8'h80) | 8'h02;
            default: return d & 8'hFE;
        endcase
    endfunction : mk
    function automatic logic [7:0] ex(input logic [7:0] a);
        case (a)
            8'h06: return 8'h40;
            8'h07: return 8'h22;
            8'h08: return {4'h0, neg, pos};
            8'h0C: return 8'h20;
            default: return sh[a];
        endcase
    endfunction : ex
    task automatic chk(input logic [7:0] g, e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a);
        scsr_mcu_i.acc(0, a, 8'h00, q);
        chk(q, ex(a));
    endtask : rd
    task automatic conclude;
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    initial forever #5 sys_clk = ~sys_clk;
    initial begin
        #200000;
        mismatches++;
        conclude();
    end
    initial begin
        foreach (sh[i]) sh[i] = 8'h00;
        for (int a = 13; a < 19; a++) sh[a] = mk(a, 8'h00);
        repeat (6) @(posedge sys_clk);
        #1 rst_n = 1;
        for (int a = 5; a < 20; a++) rd(a);
        repeat (60) begin
            sd = lf(sd);
            ra = 8'h06 + sd % 14;
            sd = lf(sd);
            scsr_mcu_i.acc(1, ra, sd, q);
            if (ra inside {[8'h0D:8'h12]}) sh[ra] = mk(ra, sd);
            rd(ra);
            sd = lf(sd);
            {neg, pos, sy} = sd[6:0];
            bc = sd[3:0] ^ sd[7:4];
            repeat (8) @(posedge sys_clk);
            #1 chk({vo, ho, deo}, sy ^ {sh[8'h0D][6:5], sh[8'h0E][7]});
            chk({op, bl}, {sh[8'h0D][7], bc[3] ? bc - 4'h7 : 4'h0});
            rd(8'h08);
        end
        // a write while the clock enable is low must not land
        ce = 0;
        scsr_mcu_i.acc(1, 8'h0F, ~sh[8'h0F], q);
        ce = 1;
        rd(8'h0F);
        for (int a = 5; a < 20; a++) rd(a);
        xv = 1;
        repeat (40) begin
            sd = lf(sd);
            xa = sd[1:0] == 0 ? sh[8'h0F][7:1] : sd[1:0] == 1 ? sh[8'h11][7:1] : sd[7:1];
            @(posedge sys_clk);
            #1 chk({xov, xo}, {1'b1, xa == sh[8'h0F][7:1] ? sh[8'h10][7:1] :
                xa == sh[8'h11][7:1] ? sh[8'h12][7:1] : xa});
            chk(xh, xa == sh[8'h0F][7:1] || xa == sh[8'h11][7:1]);
        end
        xv = 0;
        conclude();
    end
endmodule : scsr_top_tb
